/* core/result_word_regs.vh */
// Field positions, reset values and constants of the converted input word
`ifndef RESULT_WORD_REGS_VH
`define RESULT_WORD_REGS_VH

// ****************************************
// Word layout (bit 0 here is point 1)
// ****************************************
`define WORD_WIDTH       32
`define CHAN_LSB         0
`define CHAN_MSB         2
`define ZERO_LSB         3
`define ZERO_MSB         7
`define VALID_BIT        8
`define UNUSED_BIT       9
`define OPEN_BIT         10
`define SIGN_BIT         11
`define SUPPLY_BIT       12
`define UNDER_BIT        13
`define OVER_BIT         14
`define BEAT_BIT         15
`define DLO_LSB          16
`define DLO_MSB          23
`define DHI_LSB          24
`define DHI_MSB          27
`define EXT_LSB          28
`define EXT_MSB          31

// ****************************************
// Variants and reset values
// ****************************************
`define VAR_UNIPOLAR     2'h0
`define VAR_BIPOLAR      2'h1
`define VAR_CURRENT      2'h2
`define WORD_RESET       32'h00000000
`define CHAN_RESET       3'h0
`define CHAN_LAST        3'h7
`define DATA_MAX_UNI     12'hFFF
`define DATA_MIN_UNI     12'h000
`define DATA_MAX_BIP     12'h7FF
`define DATA_MIN_BIP     12'h800

`endif

/* core/sync2.v */
// Two-stage synchroniser for pin-level inputs
`timescale 1ns/1ps
module sync2 #(
    parameter W = 1
) (
    input  wire         core_clk,
    input  wire         rst,
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);
    reg [W-1:0] meta_q;

    always @(posedge core_clk) begin
        if (rst) begin
            meta_q   <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

/* core/analog_input_result_word_formatter.v */
// Formats the 32-bit converted input word presented on each total I/O scan
//
// What this block does
// - Word bit 0 maps to lowest point of the group, bit 31 highest.
// - Bits 1-8 carry channel number; only bits 1-3 significant, 4-8 zero.
// - Bit 9 valid flag follows the board-OK lamp input.
// - Current variant: bit 11 high when input below 0.4 V.
// - Bipolar: bit 12 high for negative input; otherwise always low.
// - Bit 13 high only when both +5 V and +15 V rails good.
// - Bit 14 high when input at or below range low limit.
// - Bit 15 high when input at or above range high limit.
// - Bit 16 toggles each time a channel conversion finishes.
// - Bits 17-24 hold low eight result bits, 17 the LSB.
// - Bits 25-28 hold upper four result bits, 28 the MSB.
// - Bits 29-32 each copy the sign flag of bit 12.
// - Result plus extension form 16-bit binary or two's-complement value.
// - Bipolar: result bit 28 acts as the sign of the value.
// - One 32-point block is shared by all eight channels.
// - Each scan first advances the channel, then reports that channel, wrapping after eight.
`timescale 1ns/1ps
`include "result_word_regs.vh"

module analog_input_result_word_formatter (
    input  wire        core_clk,
    input  wire        rst,
    input  wire [1:0]  variant_sel,
    input  wire        supply_5v_ok,
    input  wire        supply_15v_ok,
    input  wire        board_ok_lamp,
    input  wire        open_wire_det,
    input  wire        conv_done,
    input  wire [11:0] conv_result,
    input  wire        scan_strobe,
    output reg  [31:0] converted_input_word,
    output reg         word_update,
    output reg  [2:0]  conv_channel
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    wire [4:0] pins_s;

    sync2 #(
        .W (5)
    ) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in ({scan_strobe, conv_done, open_wire_det,
                    supply_15v_ok, supply_5v_ok}),
        .sync_out (pins_s)
    );

    wire [2:0] lamp_var_s;

    sync2 #(
        .W (3)
    ) u_sync_lamp (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in ({variant_sel, board_ok_lamp}),
        .sync_out (lamp_var_s)
    );

    wire       lamp_s = lamp_var_s[0];
    wire [1:0] var_s  = lamp_var_s[2:1];
    wire s5_s   = pins_s[0];
    wire s15_s  = pins_s[1];
    wire open_s = pins_s[2];
    wire done_s = pins_s[3];
    wire scan_s = pins_s[4];

    // ****************************************
    // Edge detection and result capture
    // ****************************************
    reg        done_prev_q;
    reg        done_rise_q;
    reg        scan_prev_q;
    reg [11:0] result_q;
    reg        open_q;
    reg        beat_q;
    reg [2:0]  chan_q;

    wire done_rise = done_s & ~done_prev_q;
    wire scan_rise = scan_s & ~scan_prev_q;

    always @(posedge core_clk) begin
        if (rst) begin
            done_prev_q <= 1'b0;
            done_rise_q <= 1'b0;
            scan_prev_q <= 1'b0;
            result_q    <= 12'h000;
            open_q      <= 1'b0;
            beat_q      <= 1'b0;
        end else begin
            done_prev_q <= done_s;
            done_rise_q <= done_rise;
            scan_prev_q <= scan_s;
            if (done_rise) begin
                result_q <= conv_result;
                open_q   <= open_s;
                beat_q   <= ~beat_q;
            end
        end
    end

    // ****************************************
    // Channel sequencer
    // ****************************************
    // advance per scan
    always @(posedge core_clk) begin
        if (rst) begin
            chan_q <= `CHAN_RESET;
        end else if (scan_rise) begin
            if (chan_q == `CHAN_LAST) begin
                chan_q <= `CHAN_RESET;
            end else begin
                chan_q <= chan_q + 3'h1;
            end
        end
    end

    // ****************************************
    // Status flag decode
    // ****************************************
    function [1:0] range_flags;
        input [1:0]  var_i;
        input [11:0] data_i;
        begin
            if (var_i == `VAR_BIPOLAR) begin
                range_flags = {data_i == `DATA_MAX_BIP, data_i == `DATA_MIN_BIP};
            end else begin
                range_flags = {data_i == `DATA_MAX_UNI, data_i == `DATA_MIN_UNI};
            end
        end
    endfunction

    wire       bipolar  = (var_s == `VAR_BIPOLAR);
    wire       current  = (var_s == `VAR_CURRENT);
    wire       sign_f   = bipolar & result_q[11];
    wire       open_f   = current & open_q;
    wire       supply_f = s5_s & s15_s;
    wire [1:0] rng_f    = range_flags(var_s, result_q);

    // ****************************************
    // Word assembly
    // ****************************************
    reg [31:0] word_d;

    always @* begin
        word_d = `WORD_RESET;
        word_d[`CHAN_MSB:`CHAN_LSB] = chan_q;
        word_d[`ZERO_MSB:`ZERO_LSB] = 5'h00;
        word_d[`VALID_BIT]          = lamp_s;
        word_d[`UNUSED_BIT]         = 1'b0;
        word_d[`OPEN_BIT]           = open_f;
        word_d[`SIGN_BIT]           = sign_f;
        word_d[`SUPPLY_BIT]         = supply_f;
        word_d[`UNDER_BIT]          = rng_f[0];
        word_d[`OVER_BIT]           = rng_f[1];
        word_d[`BEAT_BIT]           = beat_q;
        word_d[`DLO_MSB:`DLO_LSB]   = result_q[7:0];
        word_d[`DHI_MSB:`DHI_LSB]   = result_q[11:8];
        word_d[`EXT_MSB:`EXT_LSB]   = {4{sign_f}};
    end

    // ****************************************
    // Output registers
    // ****************************************
    // one shared 32-point word
    always @(posedge core_clk) begin
        if (rst) begin
            converted_input_word <= `WORD_RESET;
            word_update          <= 1'b0;
            conv_channel         <= `CHAN_RESET;
        end else begin
            converted_input_word <= word_d;
            word_update          <= done_rise_q;
            conv_channel         <= chan_q;
        end
    end

endmodule

/* verification/result_word_sva.sv */
// Assertions on the result word formatter ports
`timescale 1ns/1ps
module result_word_sva (
    input wire        core_clk,
    input wire        rst,
    input wire [1:0]  variant_sel,
    input wire        supply_5v_ok,
    input wire        supply_15v_ok,
    input wire        board_ok_lamp,
    input wire [31:0] converted_input_word,
    input wire        word_update,
    input wire [2:0]  conv_channel
);
    wire [31:0] w = converted_input_word;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence upd_s; word_update ##1 !word_update; endsequence
    AST_ZERO: assert property (w[7:3] == 5'h00) else $error("zero field set");
    AST_EXT: assert property (w[31:28] == {4{w[11]}}) else $error("bad extension");
    AST_MSB: assert property (w[11] |-> w[27]) else $error("sign not in top bit");
    AST_SIGN: assert property (word_update && variant_sel != 2'h1 |-> !w[11])
        else $error("sign on non bipolar");
    AST_PULSE: assert property (word_update |-> upd_s) else $error("update too long");
    AST_BEAT: assert property (word_update |-> w[15] != $past(w[15]))
        else $error("beat not toggled");
    AST_HOLD: assert property (!word_update |-> $stable(w[27:15]))
        else $error("data moved without update");
    AST_VALID: assert property (!$past(rst, 3) |-> w[8] == $past(board_ok_lamp, 3))
        else $error("valid bit wrong");
    AST_SUPPLY: assert property (!$past(rst, 3) |->
        w[12] == $past(supply_5v_ok & supply_15v_ok, 3)) else $error("supply bit wrong");
    AST_CHAN: assert property (conv_channel != $past(conv_channel) |->
        conv_channel - $past(conv_channel) == 3'h1) else $error("channel skipped");
endmodule
bind analog_input_result_word_formatter result_word_sva u_result_word_sva (
    .core_clk(core_clk), .rst(rst), .variant_sel(variant_sel),
    .supply_5v_ok(supply_5v_ok), .supply_15v_ok(supply_15v_ok),
    .board_ok_lamp(board_ok_lamp), .converted_input_word(converted_input_word),
    .word_update(word_update), .conv_channel(conv_channel));

/* verification/scan_host.sv */
// Controller model issuing scans and storing each channel
`timescale 1ns/1ps
module scan_host (
    input  wire        core_clk,
    input  wire        rst,
    input  wire        go,
    input  wire        word_update,
    input  wire [31:0] converted_input_word,
    output wire        scan_strobe
);
    reg [2:0]  cnt_q;
    reg [31:0] table_q [0:7];
    assign scan_strobe = cnt_q != 3'h0;
    always @(posedge core_clk) begin
        if (rst)
            cnt_q <= 3'h0;
        else if (go || cnt_q != 3'h0)
            cnt_q <= cnt_q + 3'h1;
        if (word_update)
            table_q[converted_input_word[2:0]] <= converted_input_word;
    end
endmodule

/* verification/analog_input_result_word_formatter_bench.sv */
// Self-checking bench for the result word formatter
`timescale 1ns/1ps
module analog_input_result_word_formatter_bench;
    localparam [47:0] TV = 48'h8007FF000FFF;
    reg         core_clk = 1'b0;
    reg         rst = 1'b1;
    reg  [1:0]  variant_sel = 2'h0;
    reg         s5 = 1'b1;
    reg         s15 = 1'b1;
    reg         lamp = 1'b1;
    reg         open_det = 1'b0;
    reg         conv_done = 1'b0;
    reg  [11:0] conv_result = 12'h000;
    reg         go = 1'b0;
    reg  [2:0]  ch = 3'h0;
    reg         beat = 1'b0;
    reg  [31:0] r;
    reg  [31:0] exp_q [$];
    wire        scan_strobe;
    wire [31:0] word;
    wire        word_update;
    wire [2:0]  conv_channel;
    integer     miscompares = 0;
    integer     n_compared = 0;
    integer     seed = 32'h53836bd9;
    integer     i;
    integer     v;
    always #2 core_clk = ~core_clk;
    analog_input_result_word_formatter u_analog_input_result_word_formatter (
        .core_clk(core_clk), .rst(rst), .variant_sel(variant_sel), .supply_5v_ok(s5),
        .supply_15v_ok(s15), .board_ok_lamp(lamp), .open_wire_det(open_det),
        .conv_done(conv_done), .conv_result(conv_result), .scan_strobe(scan_strobe),
        .converted_input_word(word), .word_update(word_update), .conv_channel(conv_channel));
    scan_host u_scan_host (.core_clk(core_clk), .rst(rst), .go(go),
        .word_update(word_update), .converted_input_word(word), .scan_strobe(scan_strobe));
    task check(input [95:0] name, input [31:0] seen, input [31:0] want);
        begin
            n_compared = n_compared + 1;
            if (seen !== want) begin
                miscompares = miscompares + 1;
                $display("[ERR] %0s exp %h seen %h", name, want, seen);
            end
        end
    endtask
    task final_report;
        begin
            $display("compared %0d mismatched %0d", n_compared, miscompares);
            if (miscompares == 0 && n_compared > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task scan;
        begin
            @(posedge core_clk) #1 go = 1'b1;
            @(posedge core_clk) #1 go = 1'b0;
            repeat (12) @(posedge core_clk);
            ch = ch + 3'h1;
            check("conv_channel", {29'h0, conv_channel}, {29'h0, ch});
        end
    endtask
    task convert(input [11:0] val, input op);
        reg        sg;
        reg [11:0] hi;
        begin
            sg = variant_sel == 2'h1 && val[11];
            hi = variant_sel == 2'h1 ? 12'h7FF : 12'hFFF;
            beat = ~beat;
            exp_q.push_back({{4{sg}}, val, beat, val == hi, val == ~hi, s5 & s15, sg,
                op && variant_sel == 2'h2, 1'b0, lamp, 5'h00, ch});
            @(posedge core_clk) #1 conv_result = val;
            open_det = op;
            repeat (3) @(posedge core_clk);
            #1 conv_done = 1'b1;
            repeat (4) @(posedge core_clk);
            #1 conv_done = 1'b0;
            repeat (5) @(posedge core_clk);
            #1 conv_result = ~val;
        end
    endtask
    always @(posedge core_clk) begin
        if (word_update === 1'b1) begin
            if (exp_q.size() == 0)
                check("word_update", word, ~word);
            else
                check("word", word, exp_q.pop_front());
        end
    end
    initial begin
        #100000;
        miscompares = miscompares + 1;
        final_report;
    end
    initial begin
        repeat (12) @(posedge core_clk);
        #1 rst = 1'b0;
        check("conv_channel", {29'h0, conv_channel}, 32'h0);
        for (v = 0; v < 3; v = v + 1) begin
            variant_sel = v[1:0];
            for (i = 0; i < 5; i = i + 1) begin
                r = $random(seed);
                scan;
                convert(i < 4 ? TV[i*12 +: 12] : r[11:0], r[12]);
            end
            $display("variant %0d done", v);
        end
        s15 = 1'b0;
        lamp = 1'b0;
        repeat (5) @(posedge core_clk);
        scan;
        convert(12'h123, 1'b1);
        #1 s15 = 1'b1;
        lamp = 1'b1;
        $display("supply test done");
        rst = 1'b1;
        repeat (12) @(posedge core_clk);
        check("reset_word", word, 32'h0);
        #1 rst = 1'b0;
        ch = 3'h0;
        beat = 1'b0;
        scan;
        convert(12'hABC, 1'b1);
        repeat (10) @(posedge core_clk);
        $display("reset test done");
        final_report;
    end
endmodule
